//--- design/tap_pkg.sv
// package: constants, types and decode helpers for the boundary-scan tap
// assumes: imported through tap_pkg::* by every design file except sync3
package tap_pkg;

    // widths
    localparam int IR_W   = 3;
    localparam int ID_W   = 32;
    localparam int BSR_W  = 129;
    localparam int RING_W = 128;
    localparam int RD_W   = 36;

    // instruction codes
    localparam logic [IR_W-1:0] IR_EXTEST  = 3'h0;
    localparam logic [IR_W-1:0] IR_IDCODE  = 3'h1;
    localparam logic [IR_W-1:0] IR_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] IR_PRIV0   = 3'h3;
    localparam logic [IR_W-1:0] IR_SAMPLE  = 3'h4;
    localparam logic [IR_W-1:0] IR_PRIV1   = 3'h5;
    localparam logic [IR_W-1:0] IR_PRIV2   = 3'h6;
    localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;

    // instruction preset at reset and in capture-ir
    localparam logic [IR_W-1:0] IR_PRESET = IR_IDCODE;

    // id fields, values arbitrary
    localparam logic [19:0] ID_PART  = 20'h5A5A5;
    localparam logic [10:0] ID_MAKER = 11'h2C3;
    localparam logic        ID_START = 1'h1;
    localparam logic [ID_W-1:0] ID_VALUE = {ID_PART, ID_MAKER, ID_START};

    // tms-high edges that always reach test-logic-reset
    localparam int TMS_RESET_EDGES = 5;

    // chain cell positions (1-based)
    localparam int CELL_RDATA_LSB = 1;
    localparam int CELL_RVALID    = 37;
    localparam int CELL_ECHO_LSB  = 38;
    localparam int CELL_INTERNAL  = 129;

    // no-connect cells, captured as zero; bit n-1 is cell n
    localparam logic [RING_W-1:0] NC_MASK = 128'hFF00_0000_0000_0000_0000_0000_0000_0000;

    // value captured in the internal cell
    localparam logic INTERNAL_CAPTURE = 1'h1;

    // tap controller states
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_t;

    // values driven onto the output pins
    typedef struct packed {
        logic [RD_W-1:0] rdata;
        logic            rvalid;
        logic [1:0]      echo;
    } pin_out_t;

    // test modes passed to the memory clock domain
    typedef struct packed {
        logic extest;
        logic samplez;
    } test_mode_t;

    // boundary chain selected
    function automatic logic is_boundary(input logic [IR_W-1:0] ir);
        return (ir == IR_EXTEST) || (ir == IR_SAMPLEZ) || (ir == IR_SAMPLE);
    endfunction : is_boundary

    // one-bit path selected; private codes fold onto bypass
    function automatic logic is_bypass(input logic [IR_W-1:0] ir);
        return (ir == IR_BYPASS) || (ir == IR_PRIV0) || (ir == IR_PRIV1) || (ir == IR_PRIV2);
    endfunction : is_bypass

endpackage : tap_pkg

//--- design/sync3.sv
// three-flop synchroniser; output changes once stages two and three agree
// assumes: input is a level from another clock domain or a pin
`timescale 1ns/10ps
module sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    assign next_q = (s2 & s3) | (~(s2 ^ s3) & s2) | ((s2 ^ s3) & q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
endmodule : sync3

//--- design/tap_fsm.sv
// sixteen-state test access controller, stepped by tms on rising tck
// assumes: rst_n is the power-up reset
`timescale 1ns/10ps
module tap_fsm
    import tap_pkg::*;
(
    // clock and reset
    input  wire logic tck,
    input  wire logic rst_n,
    // mode select
    input  wire logic tms,
    output tap_state_t state
);
    tap_state_t next_state;

    // held tms walks every state to tlr within five edges
    always_comb begin
        next_state = state;
        unique case (state)
            TLR:    next_state = tms ? TLR    : RTI; // R18
            RTI:    next_state = tms ? SEL_DR : RTI;
            SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
            CAP_DR: next_state = tms ? EX1_DR : SHF_DR;
            SHF_DR: next_state = tms ? EX1_DR : SHF_DR;
            EX1_DR: next_state = tms ? UPD_DR : PAU_DR;
            PAU_DR: next_state = tms ? EX2_DR : PAU_DR;
            EX2_DR: next_state = tms ? UPD_DR : SHF_DR;
            UPD_DR: next_state = tms ? SEL_DR : RTI;
            SEL_IR: next_state = tms ? TLR    : CAP_IR; // R18
            CAP_IR: next_state = tms ? EX1_IR : SHF_IR;
            SHF_IR: next_state = tms ? EX1_IR : SHF_IR;
            EX1_IR: next_state = tms ? UPD_IR : PAU_IR;
            PAU_IR: next_state = tms ? EX2_IR : PAU_IR;
            EX2_IR: next_state = tms ? UPD_IR : SHF_IR;
            UPD_IR: next_state = tms ? SEL_DR : RTI;
        endcase
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            state <= TLR; // R18
        end else begin
            state <= next_state;
        end
    end
endmodule : tap_fsm

//--- design/boundary_scan_tap.sv
// top: boundary-scan tap with instruction, bypass, id and pin chain
// assumes: tck is its own domain; core pin values arrive on mclk
//
// Summary of operation
// R01: codes 011, 101, 110 are private and give no test function.
// R02: sample captures the pin ring and shifts the chain, pins untouched.
// R03: bypass captures zero into the one-bit cell and shifts it.
// R04: bypass path is exactly one bit, the shortest tdi to tdo path.
// R05: idcode captures the fixed id value and shifts the part_identification.
// R06: id is 32 bits: part field, maker code, start bit one.
// R07: id shifts tdi into bit 31, bit 0 leaves on tdo first.
// R08: chain is 129 cells, used by all three boundary instructions.
// R09: in extest, chain cells drive read data, valid and echo pins.
// R10: in extest, shifted values reach pins only after update-dr.
// R11: not-used cells capture pin level, no-connect cells capture zero.
// R12: internal cell 129 always captures one.
// R13: in extest, cell 129 enables read data drivers, zero floats them.
// R14: termination is off during extest and sample-with-tristate.
// R15: cell 1 is lsb, 129 msb; tdi enters 129, cell 1 exits.
// R16: instruction is three bits, preset to 001 at reset and capture-ir.
// R17: new instruction acts only from update-ir.
// R18: reset at power-up or after five tms-high rising tck edges.
// R19: tdi sampled on rising tck, tdo on falling, driven in shift only.
// R20: private codes behave as bypass.
`timescale 1ns/10ps
module boundary_scan_tap
    import tap_pkg::*;
(
    // memory clock and reset
    input  wire logic              MCLK,
    input  wire logic              RSTN,
    // test port
    input  wire logic              TCK,
    input  wire logic              TMS,
    input  wire logic              TDI,
    output logic                   TDO,
    output logic                   TDO_OE,
    // pin ring levels
    input  wire logic [RING_W-1:0] RING_IN,
    // core outputs
    input  wire logic [RD_W-1:0]   CORE_RDATA,
    input  wire logic              CORE_RDATA_OE,
    input  wire logic              CORE_RVALID,
    input  wire logic [1:0]        CORE_ECHO,
    input  wire logic              CORE_ODT_EN,
    // pins
    output logic [RD_W-1:0]        RDATA_PIN,
    output logic                   RDATA_OE,
    output logic                   READ_VALID_OUTPUT,
    output logic [1:0]             ECHO_CLOCK_OUTPUT,
    output logic                   ON_DIE_TERMINATION
);

    // ---------------- tck domain ----------------
    tap_state_t        state;
    logic [IR_W-1:0]   ir_shift;
    logic [IR_W-1:0]   ir;
    logic              one_bit_pass_through;
    logic [ID_W-1:0]   part_identification;
    logic [BSR_W:1]    pin_scan_chain;
    logic [BSR_W:1]    chain_update;
    logic              update_toggle;
    logic [RING_W-1:0] ring_sync;

    logic [IR_W-1:0]   next_ir_shift;
    logic [IR_W-1:0]   next_ir;
    logic              next_bypass;
    logic [ID_W-1:0]   next_id;
    logic [BSR_W:1]    next_chain;
    logic [BSR_W:1]    next_update;
    logic              next_toggle;
    logic              next_tdo;
    logic              next_tdo_oe;

    tap_fsm u_fsm (
        .tck   (TCK),
        .rst_n (RSTN),
        .tms   (TMS),
        .state (state)
    );

    // pin levels into tck domain
    sync3 #(.W(RING_W)) u_ring_sync (
        .clk   (TCK),
        .rst_n (RSTN),
        .d     (RING_IN),
        .q     (ring_sync)
    );

    // state decodes
    wire in_tlr     = (state == TLR);
    wire cap_ir     = (state == CAP_IR);
    wire shf_ir     = (state == SHF_IR);
    wire upd_ir     = (state == UPD_IR);
    wire cap_dr     = (state == CAP_DR);
    wire shf_dr     = (state == SHF_DR);
    wire upd_dr     = (state == UPD_DR);

    // data register selection
    wire sel_bsr    = is_boundary(ir);           // R08
    wire sel_bypass = is_bypass(ir);             // R20
    wire sel_id     = (ir == IR_IDCODE);

    // captured chain image
    wire [RING_W-1:0] ring_capture = ring_sync & ~NC_MASK; // R11
    wire [BSR_W:1]    chain_capture = {INTERNAL_CAPTURE, ring_capture}; // R12

    // instruction shift and update
    assign next_ir_shift = cap_ir ? IR_PRESET :                 // R16
                           shf_ir ? {TDI, ir_shift[IR_W-1:1]} : // R19
                           ir_shift;
    assign next_ir       = in_tlr ? IR_PRESET :                 // R16
                           upd_ir ? ir_shift :                  // R17
                           ir;

    // one-bit path
    assign next_bypass   = (cap_dr && sel_bypass) ? 1'h0 :      // R03
                           (shf_dr && sel_bypass) ? TDI :       // R04
                           one_bit_pass_through;

    // part_identification
    assign next_id       = (cap_dr && sel_id) ? ID_VALUE :      // R05 R06
                           (shf_dr && sel_id) ? {TDI, part_identification[ID_W-1:1]} : // R07
                           part_identification;

    // pin chain
    assign next_chain    = (cap_dr && sel_bsr) ? chain_capture :  // R02 R08
                           (shf_dr && sel_bsr) ? {TDI, pin_scan_chain[BSR_W:2]} : // R15
                           pin_scan_chain;

    // update stage holds pins steady while shifting
    assign next_update   = (upd_dr && sel_bsr) ? pin_scan_chain : chain_update; // R10
    assign next_toggle   = (upd_dr && sel_bsr) ? ~update_toggle : update_toggle;

    // serial output source
    assign next_tdo      = shf_ir     ? ir_shift[0] :
                           sel_bsr    ? pin_scan_chain[1] :     // R15
                           sel_id     ? part_identification[0] :
                           one_bit_pass_through;                // R01 R04
    assign next_tdo_oe   = shf_ir || shf_dr;                     // R19

    // instruction shift stage
    always_ff @(posedge TCK or negedge RSTN) begin
        if (!RSTN) begin
            ir_shift <= IR_PRESET;
        end else begin
            ir_shift <= next_ir_shift;
        end
    end

    // instruction in force
    always_ff @(posedge TCK or negedge RSTN) begin
        if (!RSTN) begin
            ir <= IR_PRESET; // R16
        end else begin
            ir <= next_ir;
        end
    end

    // one-bit path cell
    always_ff @(posedge TCK or negedge RSTN) begin
        if (!RSTN) begin
            one_bit_pass_through <= 1'h0;
        end else begin
            one_bit_pass_through <= next_bypass;
        end
    end

    // part_identification
    always_ff @(posedge TCK or negedge RSTN) begin
        if (!RSTN) begin
            part_identification <= '0;
        end else begin
            part_identification <= next_id;
        end
    end

    // pin chain shift stage
    always_ff @(posedge TCK or negedge RSTN) begin
        if (!RSTN) begin
            pin_scan_chain <= '0;
        end else begin
            pin_scan_chain <= next_chain;
        end
    end

    // update stage
    always_ff @(posedge TCK or negedge RSTN) begin
        if (!RSTN) begin
            chain_update <= '0;
        end else begin
            chain_update <= next_update;
        end
    end

    // update flag for the memory side
    always_ff @(posedge TCK or negedge RSTN) begin
        if (!RSTN) begin
            update_toggle <= 1'h0;
        end else begin
            update_toggle <= next_toggle;
        end
    end

    // tdo changes on the falling edge
    always_ff @(negedge TCK or negedge RSTN) begin
        if (!RSTN) begin
            TDO    <= 1'h0;
            TDO_OE <= 1'h0;
        end else begin
            TDO    <= next_tdo;    // R19
            TDO_OE <= next_tdo_oe; // R19
        end
    end

    // test modes as levels
    test_mode_t mode_tck;
    assign mode_tck.extest  = (ir == IR_EXTEST);
    assign mode_tck.samplez = (ir == IR_SAMPLEZ);

    // ---------------- mclk domain ----------------
    test_mode_t     mode_sync;
    test_mode_t     mode_prev;
    test_mode_t     mode_m;
    test_mode_t     next_mode_m;
    logic           toggle_m;
    logic           toggle_seen;
    logic [BSR_W:1] chain_m;
    logic [BSR_W:1] next_chain_m;
    pin_out_t       pin_drive;
    pin_out_t       core_drive;
    pin_out_t       next_pins;
    logic           next_rdata_oe;
    logic           next_odt;

    sync3 #(.W(2)) u_mode_sync (
        .clk   (MCLK),
        .rst_n (RSTN),
        .d     (mode_tck),
        .q     (mode_sync)
    );

    sync3 #(.W(1)) u_toggle_sync (
        .clk   (MCLK),
        .rst_n (RSTN),
        .d     (update_toggle),
        .q     (toggle_m)
    );

    // copy update stage once its toggle has crossed
    wire new_update = toggle_m ^ toggle_seen;
    assign next_chain_m = new_update ? chain_update : chain_m; // R10
    // mode word taken only once steady for two cycles
    assign next_mode_m  = (mode_sync == mode_prev) ? mode_sync : mode_m;

    // chain cells for the driven pins
    assign pin_drive.rdata  = chain_m[CELL_RDATA_LSB +: RD_W];
    assign pin_drive.rvalid = chain_m[CELL_RVALID];
    assign pin_drive.echo   = chain_m[CELL_ECHO_LSB +: 2];

    assign core_drive.rdata  = CORE_RDATA;
    assign core_drive.rvalid = CORE_RVALID;
    assign core_drive.echo   = CORE_ECHO;

    // pin source; sample and idcode leave pins alone
    assign next_pins     = mode_m.extest ? pin_drive : core_drive;    // R09 R02
    assign next_rdata_oe = mode_m.extest  ? chain_m[CELL_INTERNAL] :  // R13
                           mode_m.samplez ? 1'h0 :
                           CORE_RDATA_OE;
    assign next_odt      = CORE_ODT_EN && !mode_m.extest && !mode_m.samplez; // R14

    // crossing state
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            toggle_seen <= 1'h0;
            chain_m     <= '0;
            mode_prev   <= '0;
            mode_m      <= '0;
        end else begin
            toggle_seen <= toggle_m;
            chain_m     <= next_chain_m;
            mode_prev   <= mode_sync;
            mode_m      <= next_mode_m;
        end
    end

    // pin values
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA_PIN         <= '0;
            READ_VALID_OUTPUT <= 1'h0;
            ECHO_CLOCK_OUTPUT <= '0;
        end else begin
            RDATA_PIN         <= next_pins.rdata;
            READ_VALID_OUTPUT <= next_pins.rvalid;
            ECHO_CLOCK_OUTPUT <= next_pins.echo;
        end
    end

    // driver and termination enables
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA_OE           <= 1'h0;
            ON_DIE_TERMINATION <= 1'h0;
        end else begin
            RDATA_OE           <= next_rdata_oe;
            ON_DIE_TERMINATION <= next_odt;
        end
    end

endmodule : boundary_scan_tap

//--- testbench/jtag_tester.sv
// tester model: drives the test port, tck runs only inside frames
// assumes: tdi idles high through a pull-up outside shifts
`timescale 1ns/10ps
module jtag_tester (
    // test port
    output logic      TCK,
    output logic      TMS,
    output logic      TDI,
    input  wire logic TDO,
    input  wire logic TDO_OE
);
    logic last_tdo;
    initial begin
        TCK = 1'h0;
        TMS = 1'h1;
        TDI = 1'h1;
    end
    // one period; tdo read before the rise, x when not driven
    task automatic step(input logic t, input logic d);
        TMS = t;
        TDI = d;
        #7.5;
        last_tdo = TDO_OE ? TDO : 1'hX;
        TCK = 1'h1;
        #7.5;
        TCK = 1'h0;
    endtask : step
    // five tms-high edges, then idle
    task automatic tms_reset();
        repeat (5) step(1'h1, 1'h1);
        step(1'h0, 1'h1);
    endtask : tms_reset
    // scan from idle, ends in exit1
    task automatic scan(input logic ir, input int n, input logic [128:0] din,
                        output logic [128:0] dout);
        dout = '0;
        repeat (4) step(1'h0, 1'h1);
        step(1'h1, 1'h1);
        if (ir) step(1'h1, 1'h1);
        step(1'h0, 1'h1);
        step(1'h0, 1'h1);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i]);
            dout[i] = last_tdo;
        end
    endtask : scan
    // update, back to idle
    task automatic update();
        step(1'h1, 1'h1);
        step(1'h0, 1'h1);
    endtask : update
endmodule : jtag_tester

//--- testbench/tap_checker.sv
// checker: port-level assertions for the boundary-scan tap
// assumes: bound to boundary_scan_tap, sees its ports only
`timescale 1ns/10ps
module tap_checker (
    // clocks and reset
    input wire logic       MCLK,
    input wire logic       RSTN,
    input wire logic       TCK,
    // test port
    input wire logic       TMS,
    input wire logic       TDO_OE,
    // core and pins
    input wire logic       CORE_RDATA_OE,
    input wire logic       CORE_ODT_EN,
    input wire logic       RDATA_OE,
    input wire logic       READ_VALID_OUTPUT,
    input wire logic [1:0] ECHO_CLOCK_OUTPUT,
    input wire logic       ON_DIE_TERMINATION
);
    leave_shift_a: assert property (@(posedge TCK) disable iff (!RSTN)
        TMS |=> !TDO_OE) else $error("tdo driven after tms high");
    shift_entry_a: assert property (@(posedge TCK) disable iff (!RSTN)
        $rose(TDO_OE) |-> !$past(TMS) && ($past(TMS, 2) || $past(TMS, 3)))
        else $error("tdo enabled off the shift path");
    shift_exit_a: assert property (@(posedge TCK) disable iff (!RSTN)
        TDO_OE && TMS |=> !TDO_OE [*3]) else $error("shift re-entered too soon");
    shift_hold_a: assert property (@(posedge TCK) disable iff (!RSTN)
        TDO_OE && !TMS |=> TDO_OE) else $error("tdo dropped while shifting");
    tms_reset_a: assert property (@(posedge TCK) disable iff (!RSTN)
        TMS [*5] |=> !TDO_OE [*4]) else $error("no reset after tms high");
    odt_request_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        ON_DIE_TERMINATION |-> $past(CORE_ODT_EN)) else $error("termination unasked");
    extest_odt_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        RDATA_OE && !$past(CORE_RDATA_OE) |-> !ON_DIE_TERMINATION)
        else $error("termination on in extest");
    reset_pins_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        !$past(RSTN) |-> !RDATA_OE && !READ_VALID_OUTPUT && ECHO_CLOCK_OUTPUT == 2'h0)
        else $error("pins not cleared by reset");
    cover property (@(posedge TCK) $rose(TDO_OE));
    cover property (@(posedge TCK) TMS [*5]);
    cover property (@(posedge MCLK) RDATA_OE && !CORE_RDATA_OE);
endmodule : tap_checker

bind boundary_scan_tap tap_checker tap_checker_i (
    .MCLK(MCLK), .RSTN(RSTN), .TCK(TCK), .TMS(TMS), .TDO_OE(TDO_OE),
    .CORE_RDATA_OE(CORE_RDATA_OE), .CORE_ODT_EN(CORE_ODT_EN), .RDATA_OE(RDATA_OE),
    .READ_VALID_OUTPUT(READ_VALID_OUTPUT), .ECHO_CLOCK_OUTPUT(ECHO_CLOCK_OUTPUT),
    .ON_DIE_TERMINATION(ON_DIE_TERMINATION));

//--- testbench/boundary_scan_tap_bench.sv
// bench: scans through the tester model, checks id, paths and pins
// assumes: design package and modules compiled first
`timescale 1ns/10ps
module boundary_scan_tap_bench import tap_pkg::*;;
    logic              mclk, rstn, tck, tms, tdi, tdo, tdo_oe;
    logic [RING_W-1:0] ring;
    logic [RD_W-1:0]   core_rdata, rdata_pin;
    logic              core_oe, core_rvalid, core_odt, rdata_oe, rvalid, on_die_termination;
    logic [1:0]        core_echo, echo;
    logic [128:0]      dout, pat;
    logic [2:0]        codes [4];
    int                fails, check_count;

    boundary_scan_tap boundary_scan_tap_i (
        .MCLK(mclk), .RSTN(rstn), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
        .TDO_OE(tdo_oe), .RING_IN(ring), .CORE_RDATA(core_rdata),
        .CORE_RDATA_OE(core_oe), .CORE_RVALID(core_rvalid), .CORE_ECHO(core_echo),
        .CORE_ODT_EN(core_odt), .RDATA_PIN(rdata_pin), .RDATA_OE(rdata_oe),
        .READ_VALID_OUTPUT(rvalid), .ECHO_CLOCK_OUTPUT(echo), .ON_DIE_TERMINATION(on_die_termination));
    jtag_tester jtag_tester_i (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe));

    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic check(input logic [128:0] seen, input logic [128:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    // instruction load, checks captured ir against IR_PRESET
    task automatic load_ir(input logic [2:0] code);
        jtag_tester_i.scan(1'h1, 3, {126'h0, code}, dout);
        jtag_tester_i.update();
        check(dout[2:0], IR_PRESET);
    endtask : load_ir
    // wait for the crossing into the memory domain
    task automatic settle();
        repeat (12) @(posedge mclk);
        #2;
    endtask : settle
    initial begin
        #300000;
        fails++;
        tally_and_finish();
    end
    initial begin
        codes = '{IR_BYPASS, IR_PRIV0, IR_PRIV1, IR_PRIV2};
        pat = {1'h1, 89'h0, 2'h1, 1'h1, 36'hA_5C3C_F00F};
        fails = 0;
        check_count = 0;
        rstn = 1'h0;
        ring = {8{16'hC3A5}};
        core_rdata = 36'h9_8765_4321;
        core_oe = 1'h1;
        core_rvalid = 1'h0;
        core_echo = 2'h2;
        core_odt = 1'h1;
        repeat (2) @(posedge mclk);
        #2 rstn = 1'h1;
        jtag_tester_i.scan(1'h0, 64, 129'h1234_ABCD, dout);
        jtag_tester_i.update();
        check(dout[63:0], {32'h1234_ABCD, ID_VALUE});
        foreach (codes[k]) begin
            load_ir(codes[k]);
            jtag_tester_i.scan(1'h0, 8, 129'hA6, dout);
            jtag_tester_i.update();
            check(dout[7:0], 8'h4C);
            settle();
            check({rdata_pin, rdata_oe, on_die_termination}, {core_rdata, core_oe, core_odt});
            check({echo, rvalid}, {core_echo, core_rvalid});
        end
        load_ir(IR_SAMPLE);
        jtag_tester_i.scan(1'h0, 129, '0, dout);
        jtag_tester_i.update();
        check(dout, {1'h1, ring & ~NC_MASK});
        settle();
        check({rdata_pin, rdata_oe, on_die_termination}, {core_rdata, core_oe, core_odt});
        check({echo, rvalid}, {core_echo, core_rvalid});
        core_oe = 1'h0;
        load_ir(IR_EXTEST);
        jtag_tester_i.scan(1'h0, 129, pat, dout);
        check(dout, {1'h1, ring & ~NC_MASK});
        repeat (3) jtag_tester_i.step(1'h0, 1'h1);
        settle();
        check({echo, rvalid, rdata_pin, rdata_oe, on_die_termination}, 41'h0);
        jtag_tester_i.step(1'h1, 1'h1);
        jtag_tester_i.update();
        settle();
        check({echo, rvalid, rdata_pin, rdata_oe, on_die_termination}, {pat[38:0], 2'h2});
        jtag_tester_i.scan(1'h0, 129, {1'h0, pat[127:0]}, dout);
        jtag_tester_i.update();
        settle();
        check(rdata_oe, 1'h0);
        @(posedge mclk);
        #2 core_oe = 1'h1;
        load_ir(IR_SAMPLEZ);
        settle();
        check({rdata_pin, rdata_oe, on_die_termination}, {core_rdata, 2'h0});
        jtag_tester_i.tms_reset();
        settle();
        check({rdata_oe, on_die_termination}, 2'h3);
        jtag_tester_i.scan(1'h1, 3, {126'h0, IR_SAMPLEZ}, dout);
        check(dout[2:0], IR_PRESET);
        settle();
        check({rdata_oe, on_die_termination}, 2'h3);
        jtag_tester_i.update();
        settle();
        check({rdata_oe, on_die_termination}, 2'h0);
        jtag_tester_i.tms_reset();
        jtag_tester_i.scan(1'h0, 32, '0, dout);
        jtag_tester_i.update();
        check(dout[31:0], ID_VALUE);
        @(posedge mclk);
        #2 core_odt = 1'h0;
        settle();
        check(on_die_termination, 1'h0);
        tally_and_finish();
    end
endmodule : boundary_scan_tap_bench
